/* core/overhead_64k_channel_adapt.sv */
// Purpose: Orderwire/user 64 kbit/s channel into and out of section overhead E1/F1.
// Assumes: Client bit clock is a sampled input; line frame strobes are one-cycle pulses.
// Notes: Slip store with octet justification on the source; latch and smooth on the sink.
// Operation
// - Source puts one client octet per frame.
// - Client bits written into elastic store.
// - Store read at line frame timing.
// - Positive justification drops one whole octet.
// - Negative justification repeats the same octet.
// - Offset absorbed only as whole octet slips.
// - Store absorbs at least 18 us wander.
// - Select input picks E1 or F1 only.
// - Sink latches selected byte each frame.
// - Sink shifts bits out at 64 kHz.
// - Trail fail gives fail flag and all-ones.
// - User source inserts F1 when E1 is selected, supplies line-timed clock.
// - User sink extracts F1 with a clock.
// - User sink fail flag and all-ones.
`timescale 1ns/1ps
`default_nettype none
module overhead_64k_channel_adapt
  import ow64_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Configuration
  input wire oh_sel_t channel_sel_i,
  // Orderwire client source side
  input wire logic client_serial_in_i,
  input wire logic client_bit_clock_i,
  input wire logic client_octet_start_i,
  // Line transmit timing and overhead out
  input wire logic line_frame_start_i,
  output oh_bytes_t section_frame_bus_o,
  // Line receive overhead in
  input wire logic frame_timing_start_i,
  input wire oh_bytes_t section_frame_bus_i,
  input wire logic trail_fail_in_i,
  // Orderwire sink toward client
  output serial_out_t channel_serial_out_o,
  output logic channel_fail_out_o,
  // User channel source and sink
  input wire logic user_channel_data_i,
  output logic user_channel_clock_o,
  output serial_out_t user_channel_data_o,
  output logic user_channel_fail_o
);

  // Shared 64 kHz divider
  logic [DIV_W-1:0] div_q, div_d;
  logic bit_tick;
  // Client capture
  logic ck_q, ck_d;
  logic [7:0] cap_q, cap_d;
  logic [2:0] cap_cnt_q, cap_cnt_d;
  logic cap_done;
  // Elastic store
  logic [7:0] mem_q [STORE_DEPTH];
  logic [PTR_W-1:0] wr_q, wr_d, wr_gray_q, wr_gray_d, rd_q, rd_d, fill;
  just_state_t jst_q, jst_d;
  logic [7:0] last_q, last_d;
  logic skip_now, rep_now;
  // User source capture
  logic [7:0] usr_q, usr_d, usr_oct_q, usr_oct_d;
  logic [2:0] usr_cnt_q, usr_cnt_d;
  // Transmit overhead
  oh_bytes_t tx_q, tx_d;
  // Sink serialisers: index 0 orderwire, 1 user channel
  logic [7:0] latch_q [2];
  logic [7:0] latch_d [2];
  logic [7:0] sh_q [2];
  logic [7:0] sh_d [2];
  logic [2:0] scnt_q [2];
  logic [2:0] scnt_d [2];
  logic [1:0] ostart_q, ostart_d;
  logic fail_q, fail_d, sclk_q, sclk_d;

  // Binary to Gray
  function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  // Gray to binary
  function automatic logic [PTR_W-1:0] from_gray(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    from_gray = b;
  endfunction : from_gray

  // Divider next value and tick
  // 64 kHz enable
  always_comb begin
    bit_tick = (div_q == DIV_LAST);
    div_d = bit_tick ? '0 : div_q + 1'b1;
    sclk_d = (div_q < DIV_HALF);
  end

  // Client bit capture on rising client clock
  // serial capture
  always_comb begin
    ck_d = client_bit_clock_i;
    cap_d = cap_q;
    cap_cnt_d = cap_cnt_q;
    cap_done = 1'b0;
    if (client_bit_clock_i && !ck_q) begin
      // Octet start realigns the bit count
      if (client_octet_start_i) begin
        cap_cnt_d = BIT_FIRST + 1'b1;
        cap_d = {7'h00, client_serial_in_i};
      end else begin
        cap_d = {cap_q[6:0], client_serial_in_i};
        cap_done = (cap_cnt_q == BIT_LAST);
        cap_cnt_d = cap_cnt_q + 1'b1;
      end
    end
  end

  // Fill level from the Gray write pointer
  // Gray pointer compare
  assign fill = from_gray(wr_gray_q) - rd_q;
  assign skip_now = (fill >= FILL_HIGH);
  assign rep_now = (fill <= FILL_LOW);

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    jst_d = jst_q;
    last_d = last_q;
    if (cap_done && (fill != STORE_DEPTH)) begin
      wr_d = wr_q + PTR_ONE;
    end
    wr_gray_d = to_gray(wr_d);
    if (line_frame_start_i) begin
      unique case (jst_q)
        // Hold off reads until half full
        J_FILL: begin
          if (fill >= FILL_MID) begin
            jst_d = J_RUN;
          end
        end
        J_RUN: begin
          if (skip_now) begin
            last_d = mem_q[ADDR_W'(rd_q + PTR_ONE)];
            rd_d = rd_q + PTR_TWO;
          end else if (rep_now) begin
            last_d = last_q;
          end else begin
            last_d = mem_q[rd_q[ADDR_W-1:0]];
            rd_d = rd_q + PTR_ONE;
          end
        end
      endcase
    end
  end

  // User channel source capture at 64 kHz
  // user octet capture
  always_comb begin
    usr_d = usr_q;
    usr_cnt_d = usr_cnt_q;
    usr_oct_d = usr_oct_q;
    if (bit_tick) begin
      usr_d = {usr_q[6:0], user_channel_data_i};
      usr_cnt_d = usr_cnt_q + 1'b1;
      if (usr_cnt_q == BIT_LAST) begin
        usr_oct_d = {usr_q[6:0], user_channel_data_i};
      end
    end
  end

  // Transmit overhead bytes per frame
  always_comb begin
    tx_d = tx_q;
    if (line_frame_start_i) begin
      if (channel_sel_i == SEL_E1) begin
        tx_d.e1 = last_d;
        tx_d.f1 = usr_oct_q;
      end else begin
        tx_d.e1 = IDLE_OCTET;
        tx_d.f1 = last_d;
      end
    end
  end

  // Sink latch and smoothing serialisers
  always_comb begin
    fail_d = trail_fail_in_i;
    for (int c = 0; c < 2; c++) begin
      latch_d[c] = latch_q[c];
      sh_d[c] = sh_q[c];
      scnt_d[c] = scnt_q[c];
      ostart_d[c] = ostart_q[c];
    end
    if (frame_timing_start_i) begin
      latch_d[0] = (channel_sel_i == SEL_E1) ? section_frame_bus_i.e1 : section_frame_bus_i.f1;
      latch_d[1] = section_frame_bus_i.f1;
    end
    if (bit_tick) begin
      for (int c = 0; c < 2; c++) begin
        scnt_d[c] = scnt_q[c] + 1'b1;
        ostart_d[c] = (scnt_q[c] == BIT_LAST);
        if (scnt_q[c] == BIT_LAST) begin
          sh_d[c] = trail_fail_in_i ? ALL_ONES : latch_q[c];
        end else begin
          sh_d[c] = {sh_q[c][6:0], 1'b1};
        end
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= '0;
      ck_q <= 1'b0;
      cap_q <= '0;
      cap_cnt_q <= BIT_FIRST;
      wr_q <= PTR_ZERO;
      wr_gray_q <= PTR_ZERO;
      rd_q <= PTR_ZERO;
      jst_q <= J_FILL;
      last_q <= IDLE_OCTET;
      usr_q <= '0;
      usr_cnt_q <= BIT_FIRST;
      usr_oct_q <= IDLE_OCTET;
      tx_q <= '{e1: IDLE_OCTET, f1: IDLE_OCTET};
      fail_q <= 1'b0;
      sclk_q <= 1'b0;
      ostart_q <= '0;
      for (int c = 0; c < 2; c++) begin
        latch_q[c] <= ALL_ONES;
        sh_q[c] <= ALL_ONES;
        scnt_q[c] <= BIT_FIRST;
      end
    end else begin
      div_q <= div_d;
      ck_q <= ck_d;
      cap_q <= cap_d;
      cap_cnt_q <= cap_cnt_d;
      wr_q <= wr_d;
      wr_gray_q <= wr_gray_d;
      rd_q <= rd_d;
      jst_q <= jst_d;
      last_q <= last_d;
      usr_q <= usr_d;
      usr_cnt_q <= usr_cnt_d;
      usr_oct_q <= usr_oct_d;
      tx_q <= tx_d;
      fail_q <= fail_d;
      sclk_q <= sclk_d;
      ostart_q <= ostart_d;
      for (int c = 0; c < 2; c++) begin
        latch_q[c] <= latch_d[c];
        sh_q[c] <= sh_d[c];
        scnt_q[c] <= scnt_d[c];
      end
    end
  end

  // Store array, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (wr_d != wr_q) begin
      mem_q[wr_q[ADDR_W-1:0]] <= cap_d;
    end
  end

  // Outputs straight from flops
  assign section_frame_bus_o = tx_q;
  assign channel_serial_out_o = '{data: sh_q[0][MSB], clock: sclk_q, octet_start: ostart_q[0]};
  assign user_channel_data_o = '{data: sh_q[1][MSB], clock: sclk_q, octet_start: ostart_q[1]};
  assign user_channel_clock_o = sclk_q;
  assign channel_fail_out_o = fail_q;
  assign user_channel_fail_o = fail_q;

  // Checks
  property p_unsel_idle;
    @(posedge clk_i) disable iff (!arst_n_i)
    line_frame_start_i && channel_sel_i == SEL_F1 |=> section_frame_bus_o.e1 == IDLE_OCTET;
  endproperty
  a_unsel_idle: assert property (p_unsel_idle) else $error("unselected E1 not idle");
  property p_skip;
    @(posedge clk_i) disable iff (!arst_n_i)
    line_frame_start_i && jst_q == J_RUN && skip_now |=> rd_q == $past(rd_q) + PTR_TWO;
  endproperty
  a_skip: assert property (p_skip) else $error("skip did not drop one octet");
  property p_repeat;
    @(posedge clk_i) disable iff (!arst_n_i)
    line_frame_start_i && jst_q == J_RUN && !skip_now && rep_now
      |=> $stable(rd_q) && last_q == $past(last_q);
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat did not resend octet");
  property p_whole_octet;
    @(posedge clk_i) disable iff (!arst_n_i)
    !line_frame_start_i |=> $stable(rd_q);
  endproperty
  a_whole_octet: assert property (p_whole_octet) else $error("read moved off frame");
  property p_no_overflow;
    @(posedge clk_i) disable iff (!arst_n_i)
    fill <= STORE_DEPTH;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("store overflow");
  property p_fail_fwd;
    @(posedge clk_i) disable iff (!arst_n_i)
    trail_fail_in_i |=> channel_fail_out_o && user_channel_fail_o;
  endproperty
  a_fail_fwd: assert property (p_fail_fwd) else $error("fail not forwarded");
  property p_ais_load;
    @(posedge clk_i) disable iff (!arst_n_i)
    bit_tick && scnt_q[0] == BIT_LAST && trail_fail_in_i |=> sh_q[0] == ALL_ONES;
  endproperty
  a_ais_load: assert property (p_ais_load) else $error("no all-ones under fail");
  property p_tick_space;
    @(posedge clk_i) disable iff (!arst_n_i)
    bit_tick |=> !bit_tick [*8];
  endproperty
  a_tick_space: assert property (p_tick_space) else $error("bit tick too fast");
  property p_latch;
    @(posedge clk_i) disable iff (!arst_n_i)
    frame_timing_start_i |=> latch_q[1] == $past(section_frame_bus_i.f1);
  endproperty
  a_latch: assert property (p_latch) else $error("F1 not latched");
endmodule : overhead_64k_channel_adapt
`default_nettype wire

/* inc/ow64_pkg.sv */
// Purpose: Shared constants and types for the 64 kbit/s overhead channel adapter.
// Assumes: One 40 MHz clock; client and line strobes arrive synchronous to it.
// Notes: Bit-period counts are derived from the clock rate by expression; store and octet counts are literals.
package ow64_pkg;
  // Clock and channel bit rate
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BIT_HZ = 64_000;
  // Clock cycles per 64 kHz bit period (625 at 40 MHz)
  localparam int unsigned BIT_DIV = CLK_HZ / BIT_HZ;
  localparam int unsigned DIV_W = 10;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(BIT_DIV / 2);
  // Octet framing
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int unsigned MSB = 7;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] IDLE_OCTET = 8'hFF;
  // Elastic store: 8 octets (1 ms of slack, far above 18 us of wander)
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned PTR_W = 4;
  localparam logic [PTR_W-1:0] STORE_DEPTH = 4'h8;
  localparam logic [PTR_W-1:0] FILL_LOW = 4'h2;
  localparam logic [PTR_W-1:0] FILL_MID = 4'h4;
  localparam logic [PTR_W-1:0] FILL_HIGH = 4'h6;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam logic [PTR_W-1:0] PTR_TWO = 4'h2;
  localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
  // Which overhead byte carries the 64 kbit/s channel
  typedef enum logic {SEL_E1 = 1'b0, SEL_F1 = 1'b1} oh_sel_t;
  // Justification engine states, Gray along fill -> run
  typedef enum logic [1:0] {J_FILL = 2'b00, J_RUN = 2'b01} just_state_t;
  // The two 64 kbit/s overhead bytes of a frame
  typedef struct packed {
    logic [7:0] e1;
    logic [7:0] f1;
  } oh_bytes_t;
  // Serial channel toward a client
  typedef struct packed {
    logic data;
    logic clock;
    logic octet_start;
  } serial_out_t;
endpackage : ow64_pkg

/* verification/ow64_client_model.sv */
// Purpose: Client model, 64 kbit/s octet stream into the adapter.
// Assumes: Bit period of BIT_CYC clk_i cycles.
// Notes: Octets count up from 8'h10, MSB first.
`timescale 1ns/1ps
`default_nettype none
module ow64_client_model #(
  parameter int BIT_CYC = 625
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Serial stream
  output logic serial_o,
  output logic bit_clock_o,
  output logic octet_start_o
);
  int cnt; // Cycle within bit
  logic [2:0] idx_q; // Bit within octet
  logic [7:0] oct_q; // Octet being sent
  always @(negedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 0;
      idx_q <= 3'h0;
      oct_q <= 8'h10;
      bit_clock_o <= 1'b0;
      serial_o <= 1'b1;
      octet_start_o <= 1'b0;
    end else begin
      cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
      // New bit with clock low
      if (cnt == 0) begin
        serial_o <= oct_q[3'h7 - idx_q];
        octet_start_o <= (idx_q == 3'h0);
        bit_clock_o <= 1'b0;
      end
      // Rise mid bit, data stable
      if (cnt == BIT_CYC / 2) begin
        bit_clock_o <= 1'b1;
      end
      if (cnt == BIT_CYC - 1) begin
        idx_q <= idx_q + 3'h1;
        if (idx_q == 3'h7) begin
          oct_q <= oct_q + 8'h01;
        end
      end
    end
  end
endmodule : ow64_client_model
`default_nettype wire

/* verification/testbench.sv */
// Purpose: Self-checking bench for the 64 kbit/s overhead adapter.
// Assumes: 40 MHz clock, inputs driven at falling edge.
// Notes: Line frame spacing is varied to force slips.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ow64_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  oh_sel_t channel_sel_i = SEL_E1;
  logic cl_d, cl_ck, cl_st; // Client model lines
  logic line_frame_start_i = 1'b0;
  logic frame_timing_start_i = 1'b0;
  logic trail_fail_in_i = 1'b0;
  logic user_channel_data_i = 1'b0;
  logic user_channel_clock_o, channel_fail_out_o, user_channel_fail_o;
  oh_bytes_t section_frame_bus_o;
  oh_bytes_t section_frame_bus_i = 16'hffff;
  serial_out_t channel_serial_out_o, user_channel_data_o;
  int n_fail = 0;
  int checked = 0;
  int line_gap = 5000;
  int n_rep = 0;
  int n_drop = 0;
  logic mon_on = 1'b1;
  logic usr_ck_q = 1'b0; // Last seen level of the supplied user clock
  logic [2:0] usr_bit = 3'h0; // Bit within the user octet
  logic [7:0] usr_pat = 8'h00; // Random user octet, sent over and over
  logic [31:0] seed = 32'h2a69_cd6b;
  event rx_ev;

  always #12.5 clk_i = ~clk_i;

  ow64_client_model client (.clk_i(clk_i), .arst_n_i(arst_n_i), .serial_o(cl_d),
    .bit_clock_o(cl_ck), .octet_start_o(cl_st));

  // user client on supplied clock
  // One bit per rise of the line-derived clock, MSB first, aligned from reset
  always @(negedge clk_i) begin
    if (user_channel_clock_o && !usr_ck_q) begin
      user_channel_data_i = usr_pat[3'h7 - usr_bit];
      usr_bit = usr_bit + 3'h1;
    end
    usr_ck_q = user_channel_clock_o;
  end

  overhead_64k_channel_adapt DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .channel_sel_i(channel_sel_i), .client_serial_in_i(cl_d), .client_bit_clock_i(cl_ck),
    .client_octet_start_i(cl_st), .line_frame_start_i(line_frame_start_i),
    .section_frame_bus_o(section_frame_bus_o), .frame_timing_start_i(frame_timing_start_i),
    .section_frame_bus_i(section_frame_bus_i), .trail_fail_in_i(trail_fail_in_i),
    .channel_serial_out_o(channel_serial_out_o), .channel_fail_out_o(channel_fail_out_o),
    .user_channel_data_i(user_channel_data_i), .user_channel_clock_o(user_channel_clock_o),
    .user_channel_data_o(user_channel_data_o), .user_channel_fail_o(user_channel_fail_o));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
  endfunction : lfsr

  // Legal step between frames: repeat, next, or one skipped
  function automatic logic step_ok(input logic [7:0] p, input logic [7:0] c);
    return (c - p) <= 8'h02;
  endfunction : step_ok

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // Collect one octet from a sink output, mid-bit sampling
  task automatic get_octet(input bit usr, output logic [7:0] o);
    serial_out_t s;
    logic pv;
    s = usr ? user_channel_data_o : channel_serial_out_o;
    do begin
      pv = s.octet_start;
      @(negedge clk_i);
      s = usr ? user_channel_data_o : channel_serial_out_o;
    end while (!(pv === 1'b0 && s.octet_start === 1'b1));
    repeat (312) @(negedge clk_i);
    for (int i = 7; i >= 0; i--) begin
      o[i] = usr ? user_channel_data_o.data : channel_serial_out_o.data;
      if (i > 0) repeat (625) @(negedge clk_i);
    end
  endtask : get_octet

  // Receive frames every 125 us
  initial begin : rx_gen
    @(posedge arst_n_i);
    forever begin
      repeat (4999) @(negedge clk_i);
      frame_timing_start_i = 1'b1;
      @(negedge clk_i);
      frame_timing_start_i = 1'b0;
      -> rx_ev;
    end
  end

  // Transmit frames and slot monitor
  initial begin : line_gen
    logic [7:0] prev;
    logic live;
    live = 1'b0;
    prev = 8'h00;
    @(posedge arst_n_i);
    forever begin
      repeat (line_gap - 1) @(negedge clk_i);
      line_frame_start_i = 1'b1;
      @(negedge clk_i);
      line_frame_start_i = 1'b0;
      @(negedge clk_i);
      if (mon_on && section_frame_bus_o.e1 !== 8'hff) begin
        if (live) begin
          check({7'h00, step_ok(prev, section_frame_bus_o.e1)}, 8'h01);
          check(section_frame_bus_o.f1, usr_pat);
          n_rep += int'(section_frame_bus_o.e1 == prev);
          n_drop += int'(section_frame_bus_o.e1 == prev + 8'h02);
        end
        prev = section_frame_bus_o.e1;
        live = 1'b1;
      end
    end
  end

  initial begin : watchdog
    // Tests need about 101k cycles; this limit of 105k cycles sits a little above that
    #(105_000 * 25);
    n_fail++;
    $display("BAD %0t watchdog", $time);
    tally_and_finish();
  end

  initial begin : main
    logic [7:0] o;
    realtime t0;
    seed = lfsr(seed);
    usr_pat = seed[31:24];
    repeat (10) @(negedge clk_i);
    check(section_frame_bus_o.e1, 8'hff);
    check({7'h00, channel_fail_out_o}, 8'h00);
    arst_n_i = 1'b1;
    fork
      begin
        repeat (4) @(posedge line_frame_start_i);
        line_gap = 2500;
        repeat (6) @(posedge line_frame_start_i);
        line_gap = 10000;
        repeat (5) @(posedge line_frame_start_i);
      end
      begin
        for (int k = 0; k < 3; k++) begin
          seed = lfsr(seed);
          section_frame_bus_i = seed[15:0];
          @(rx_ev);
          get_octet(1'b0, o);
          check(o, seed[15:8]);
          get_octet(1'b1, o);
          check(o, seed[7:0]);
          $display("sink case %0d done", k);
        end
        trail_fail_in_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check({6'h00, channel_fail_out_o, user_channel_fail_o}, 8'h03);
        get_octet(1'b0, o);
        check(o, 8'hff);
        get_octet(1'b1, o);
        check(o, 8'hff);
        trail_fail_in_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check({6'h00, channel_fail_out_o, user_channel_fail_o}, 8'h00);
        get_octet(1'b0, o);
        check(o, seed[15:8]);
        $display("fail case done");
      end
    join
    check({7'h00, n_rep > 0}, 8'h01);
    check({7'h00, n_drop > 0}, 8'h01);
    $display("slip case done");
    mon_on = 1'b0;
    channel_sel_i = SEL_F1;
    line_gap = 5000;
    seed = lfsr(seed);
    section_frame_bus_i = seed[15:0];
    repeat (1) @(posedge line_frame_start_i);
    repeat (2) @(negedge clk_i);
    check(section_frame_bus_o.e1, 8'hff);
    check({7'h00, section_frame_bus_o.f1 !== 8'hff}, 8'h01);
    get_octet(1'b0, o);
    check(o, seed[7:0]);
    @(posedge user_channel_clock_o);
    t0 = $realtime;
    @(negedge clk_i);
    check({6'h00, channel_serial_out_o.clock, user_channel_data_o.clock}, 8'h03);
    repeat (400) @(negedge clk_i);
    check({6'h00, channel_serial_out_o.clock, user_channel_data_o.clock}, 8'h00);
    @(posedge user_channel_clock_o);
    check({7'h00, ($realtime - t0) == 15625.0}, 8'h01);
    $display("select case done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
